/* eesl_pkg.sv */
// constants and state types for the serial byte memory slave
package eesl_pkg;
	localparam int MEM_BYTES = 256;
	localparam int PAGE_BYTES = 8;
	localparam int MULTI_BYTES = 4;
	// arbitrary value, not tied to any real part
	localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h5;
	localparam int CLK_MHZ = 25;
	localparam int PROG_TIME_US = 5;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [2:0] PAGE_MASK = 3'h7;
	localparam logic [2:0] MULTI_MASK = 3'h3;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_SUPPLY = 2;
	localparam int PIN_BURST = 3;
	localparam int PIN_WP = 4;
	localparam int PIN_CS = 5;
	localparam int PIN_COUNT = 8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_DEVSEL, ST_ACKDEV, ST_ADDR, ST_ACKADDR, ST_WDATA,
		ST_ACKDATA, ST_RDATA, ST_RACK, ST_WAITSTOP, ST_PROG
	} eesl_state_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] pins1;
		logic [PIN_COUNT-1:0] pins2;
		logic sclPrev;
		logic sdaPrev;
		logic [2:0] togSync;
		eesl_state_t state;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic rw;
		logic acked;
		logic [7:0] addr;
		logic [7:0][7:0] lanes;
		logic [7:0] valid;
		logic [15:0] progCnt;
		logic sdaOe;
		logic sdaOut;
		logic busy;
	} eesl_sys_t;

	typedef struct packed {
		logic bitVal;
		logic toggle;
	} eesl_link_t;

	localparam eesl_sys_t SYS_RESET = '0;
	localparam eesl_link_t LINK_RESET = '0;
endpackage

/* eesl_slave.sv */
// two-wire slave front end and command logic of a 256-byte memory
`timescale 1ns/1ns

// Notes on behaviour
// - the array holds 256 bytes, addressed by an 8-bit pointer
// - nothing is answered unless a START opened the transaction
// - select byte upper nibble must equal the type code
// - select bits 3..1 must equal the chip select straps
// - select byte ends in direction bit, then the device acknowledges
// - bytes move most significant bit first
// - every received byte during writes is acknowledged low in slot nine
// - read select right after START returns the byte at the pointer
// - write select, address, repeated START, read select gives random read
// - reads continue with following bytes while the master acknowledges
// - single byte write works at either burst select level
// - burst select high: up to four bytes per write
// - burst select low: up to eight bytes per write
// - an open burst select pin reads high
// - protect variant drops burst select and the four-byte mode
// - protect pin high blocks writes, low lets them through
// - an open protect pin reads low
// - while supply is not good the device is silent and idle
// - STOP after a write starts the timed programming cycle
// - during programming START is not watched
// - standby after a read only on STOP following a not-acknowledge
// - data sampled on rising SCL, master changes SDA only while SCL low
module eesl_slave #(
	parameter logic [3:0] TYPE_CODE = eesl_pkg::TYPE_CODE_DEFAULT,
	parameter bit HAS_WP = 1'b0,
	parameter logic [15:0] PROG_CYCLES = 16'(eesl_pkg::PROG_CYCLES)
) (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// two-wire link
	input wire logic sclClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// straps and supply
	input wire logic [2:0] chip_select_straps,
	input wire logic burstSel = 1'b1,
	input wire logic write_protect_input = 1'b0,
	input wire logic supplyOk,
	// status
	output logic busy
);
	eesl_pkg::eesl_sys_t s;
	eesl_pkg::eesl_sys_t next_s;
	eesl_pkg::eesl_link_t l;
	eesl_pkg::eesl_link_t next_l;
	logic [7:0] mem [eesl_pkg::MEM_BYTES];

	logic sclHigh;
	logic sdaLevel;
	logic pwrGood;
	logic wpOn;
	logic [2:0] blkMask;
	logic [2:0] csNow;
	logic startEv;
	logic stopEv;
	logic sclFall;
	logic sclRise;
	logic bitIn;
	logic quiet;
	logic [7:0] memByte;
	logic [7:0] nextAddr;

	function automatic logic [2:0] block_mask(input logic hasWp, input logic burst);
		block_mask = (hasWp || !burst) ? eesl_pkg::PAGE_MASK : eesl_pkg::MULTI_MASK;
	endfunction

	// link side: bit capture on rising SCL, toggle marks a new bit
	always_comb begin
		next_l = l;
		next_l.bitVal = sdaIn;
		next_l.toggle = ~l.toggle;
	end

	always_ff @(posedge sclClk or negedge reset_n) begin
		if (!reset_n) begin
			l <= eesl_pkg::LINK_RESET;
		end else begin
			l <= next_l;
		end
	end

	assign sclHigh = s.pins2[eesl_pkg::PIN_SCL];
	assign sdaLevel = s.pins2[eesl_pkg::PIN_SDA];
	assign pwrGood = s.pins2[eesl_pkg::PIN_SUPPLY];
	assign wpOn = HAS_WP && s.pins2[eesl_pkg::PIN_WP];
	assign blkMask = block_mask(HAS_WP, s.pins2[eesl_pkg::PIN_BURST]);
	assign csNow = s.pins2[eesl_pkg::PIN_CS +: 3];
	assign startEv = sclHigh && s.sclPrev && s.sdaPrev && !sdaLevel;
	assign stopEv = sclHigh && s.sclPrev && !s.sdaPrev && sdaLevel;
	assign sclFall = s.sclPrev && !sclHigh;
	assign sclRise = s.togSync[2] ^ s.togSync[1];
	// stable by the time the toggle has crossed over
	assign bitIn = l.bitVal;
	assign quiet = pwrGood && !startEv && !stopEv && s.state != eesl_pkg::ST_PROG;
	assign memByte = mem[s.addr];
	assign nextAddr = (s.addr & ~{5'h00, blkMask}) | ((s.addr + 8'h01) & {5'h00, blkMask});

	always_comb begin
		next_s = s;
		next_s.pins1 = {chip_select_straps, write_protect_input, burstSel, supplyOk, sdaIn, sclIn};
		next_s.pins2 = s.pins1;
		next_s.sclPrev = sclHigh;
		next_s.sdaPrev = sdaLevel;
		next_s.togSync = {s.togSync[1:0], l.toggle};
		if (!pwrGood) begin
			next_s.state = eesl_pkg::ST_IDLE;
			next_s.sdaOe = 1'b0;
			next_s.busy = 1'b0;
		end else if (s.state == eesl_pkg::ST_PROG) begin
			// bus ignored until the cycle ends
			next_s.progCnt = s.progCnt + 16'h0001;
			if (s.progCnt == PROG_CYCLES - 16'h0001) begin
				next_s.state = eesl_pkg::ST_IDLE;
				next_s.busy = 1'b0;
			end
		end else if (startEv) begin
			next_s.state = eesl_pkg::ST_DEVSEL;
			next_s.bitCnt = 4'h0;
			next_s.sdaOe = 1'b0;
		end else if (stopEv) begin
			next_s.sdaOe = 1'b0;
			if ((s.state == eesl_pkg::ST_WDATA || s.state == eesl_pkg::ST_ACKDATA) && s.valid != 8'h00 && !wpOn) begin
				next_s.state = eesl_pkg::ST_PROG;
				next_s.busy = 1'b1;
				next_s.progCnt = 16'h0000;
			end else if (s.state == eesl_pkg::ST_RDATA || s.state == eesl_pkg::ST_RACK) begin
				next_s.state = s.state;
				next_s.sdaOe = s.sdaOe;
			end else begin
				next_s.state = eesl_pkg::ST_IDLE;
			end
		end else begin
			case (s.state)
				eesl_pkg::ST_DEVSEL, eesl_pkg::ST_ADDR, eesl_pkg::ST_WDATA: begin
					if (sclRise && s.bitCnt < eesl_pkg::BYTE_BITS) begin
						next_s.shift = {s.shift[6:0], bitIn};
						next_s.bitCnt = s.bitCnt + 4'h1;
					end else if (sclFall && s.bitCnt == eesl_pkg::BYTE_BITS) begin
						next_s.bitCnt = 4'h0;
						next_s.sdaOe = 1'b1;
						if (s.state == eesl_pkg::ST_DEVSEL) begin
							if (s.shift[7:4] == TYPE_CODE && s.shift[3:1] == csNow) begin
								next_s.rw = s.shift[0];
								next_s.state = eesl_pkg::ST_ACKDEV;
							end else begin
								next_s.sdaOe = 1'b0;
								next_s.state = eesl_pkg::ST_IDLE;
							end
						end else if (s.state == eesl_pkg::ST_ADDR) begin
							next_s.addr = s.shift;
							next_s.state = eesl_pkg::ST_ACKADDR;
						end else begin
							next_s.lanes[s.addr[2:0]] = s.shift;
							next_s.valid[s.addr[2:0]] = 1'b1;
							next_s.addr = nextAddr;
							next_s.state = eesl_pkg::ST_ACKDATA;
						end
					end
				end
				eesl_pkg::ST_ACKDEV: begin
					if (sclFall) begin
						if (s.rw) begin
							next_s.state = eesl_pkg::ST_RDATA;
							next_s.shift = {memByte[6:0], 1'b0};
							next_s.sdaOe = ~memByte[7];
							next_s.bitCnt = 4'h1;
						end else begin
							next_s.state = eesl_pkg::ST_ADDR;
							next_s.sdaOe = 1'b0;
							next_s.valid = 8'h00;
						end
					end
				end
				eesl_pkg::ST_ACKADDR, eesl_pkg::ST_ACKDATA: begin
					if (sclFall) begin
						next_s.state = eesl_pkg::ST_WDATA;
						next_s.sdaOe = 1'b0;
					end
				end
				eesl_pkg::ST_RDATA: begin
					if (sclFall) begin
						if (s.bitCnt == eesl_pkg::BYTE_BITS) begin
							next_s.sdaOe = 1'b0;
							next_s.state = eesl_pkg::ST_RACK;
							next_s.addr = s.addr + 8'h01;
							next_s.bitCnt = 4'h0;
						end else begin
							next_s.sdaOe = ~s.shift[7];
							next_s.shift = {s.shift[6:0], 1'b0};
							next_s.bitCnt = s.bitCnt + 4'h1;
						end
					end
				end
				eesl_pkg::ST_RACK: begin
					if (sclRise) begin
						next_s.acked = ~bitIn;
					end else if (sclFall) begin
						if (s.acked) begin
							next_s.state = eesl_pkg::ST_RDATA;
							next_s.shift = {memByte[6:0], 1'b0};
							next_s.sdaOe = ~memByte[7];
							next_s.bitCnt = 4'h1;
						end else begin
							next_s.state = eesl_pkg::ST_WAITSTOP;
						end
					end
				end
				eesl_pkg::ST_IDLE, eesl_pkg::ST_WAITSTOP: begin
					next_s.state = s.state;
				end
				default: begin
					next_s.state = eesl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s <= eesl_pkg::SYS_RESET;
		end else begin
			s <= next_s;
		end
	end

	// one buffered byte per cycle at the start of programming
	always_ff @(posedge clk_sys) begin
		if (s.state == eesl_pkg::ST_PROG && s.progCnt < 16'(eesl_pkg::PAGE_BYTES) && s.valid[s.progCnt[2:0]]) begin
			mem[{s.addr[7:3], s.progCnt[2:0]}] <= s.lanes[s.progCnt[2:0]];
		end
	end

	assign sdaOut = s.sdaOut;
	assign sdaOe = s.sdaOe;
	assign busy = s.busy;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	type_mismatch_a: assert property (quiet && s.state == eesl_pkg::ST_DEVSEL && sclFall && s.bitCnt == 4'h8 && s.shift[7:4] != TYPE_CODE |=> !sdaOe) else $error("select answered with wrong type");
	strap_mismatch_a: assert property (quiet && s.state == eesl_pkg::ST_DEVSEL && sclFall && s.bitCnt == 4'h8 && s.shift[3:1] != csNow |=> s.state == eesl_pkg::ST_IDLE) else $error("select answered with wrong straps");
	read_msb_a: assert property (quiet && s.state == eesl_pkg::ST_RDATA && sclFall && s.bitCnt < 4'h8 |=> sdaOe == !$past(s.shift[7])) else $error("read bit out of order");
	write_ack_a: assert property (quiet && s.state == eesl_pkg::ST_WDATA && sclFall && s.bitCnt == 4'h8 |=> sdaOe && s.state == eesl_pkg::ST_ACKDATA) else $error("write byte not acknowledged");
	supply_silent_a: assert property (!pwrGood |=> !sdaOe && !busy) else $error("active without supply");
	prog_start_a: assert property (pwrGood && s.state == eesl_pkg::ST_WDATA && stopEv && s.valid != 8'h00 && !wpOn |=> busy ##1 busy) else $error("programming not started");
	prog_deaf_a: assert property (s.state == eesl_pkg::ST_PROG && s.progCnt < 16'h0002 && pwrGood |=> s.state == eesl_pkg::ST_PROG) else $error("bus watched while programming");
	protect_block_a: assert property (pwrGood && s.state != eesl_pkg::ST_PROG && wpOn && stopEv |=> !busy) else $error("write while protected");
	read_hold_a: assert property (pwrGood && s.state == eesl_pkg::ST_RDATA && stopEv |=> s.state == eesl_pkg::ST_RDATA) else $error("standby without not-acknowledge");
endmodule

/* eesl_master.sv */
// behavioural two-wire bus master that drives the clock and opens frames
`timescale 1ns/1ns
module eesl_master (
	// bus wires
	output logic scl,
	output logic sdaDrv,
	input wire logic sda
);
	// clock stands high between frames
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b0;
	end
	task automatic startCond();
		#160 sdaDrv = 1'b0;
		#160 scl = 1'b1;
		#320 sdaDrv = 1'b1;
		#320 scl = 1'b0;
	endtask
	task automatic stopCond();
		#160 sdaDrv = 1'b1;
		#160 scl = 1'b1;
		#320 sdaDrv = 1'b0;
		#320;
	endtask
	// data moves only while the clock is low
	task automatic clockBit(input logic b, output logic s);
		#160 sdaDrv = ~b;
		#160 scl = 1'b1;
		#160 s = sda;
		#160 scl = 1'b0;
	endtask
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clockBit(d[i], s);
		clockBit(1'b1, s);
		ack = ~s;
	endtask
	task automatic recvByte(input logic ackIt, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i]);
		clockBit(~ackIt, s);
	endtask
endmodule

/* i2c_eeprom_slave_2kbit_test.sv */
// self-checking bench for the serial byte memory slave
`timescale 1ns/1ns
module i2c_eeprom_slave_2kbit_test;
	localparam logic [2:0] STRAPS = 3'h5;
	localparam logic [7:0] SEL_W = {eesl_pkg::TYPE_CODE_DEFAULT, STRAPS, 1'b0};
	localparam logic [7:0] SEL_R = {eesl_pkg::TYPE_CODE_DEFAULT, STRAPS, 1'b1};
	typedef struct {logic [7:0] addr; logic [7:0] data; logic burst;} eesl_row_t;
	eesl_row_t rows[4] = '{'{8'h00, 8'hA5, 1'b1}, '{8'h3C, 8'h5A, 1'b0}, '{8'hFF, 8'hC3, 1'b1}, '{8'h80, 8'h01, 1'b0}};
	logic clk_sys = 1'b0;
	logic reset_n = 1'b1;
	logic burstSel = 1'b1;
	logic supplyOk = 1'b1;
	logic wp = 1'b0;
	logic scl, mOe, sOe, sOut, busy, ack;
	logic sOe2, sOut2, busy2;
	logic [7:0] d;
	wire logic sda = ~(mOe | sOe | sOe2);
	int bad_count = 0;
	int total_checks = 0;
	always #20 clk_sys = ~clk_sys;
	eesl_slave #(.PROG_CYCLES(16'h0100)) eesl_slave_i (.clk_sys(clk_sys), .reset_n(reset_n), .sclClk(scl),
		.sclIn(scl), .sdaIn(sda), .sdaOut(sOut), .sdaOe(sOe), .chip_select_straps(STRAPS),
		.burstSel(burstSel), .write_protect_input(1'b0), .supplyOk(supplyOk), .busy(busy));
	// protect variant on the same bus, straps 2
	eesl_slave #(.HAS_WP(1'b1), .PROG_CYCLES(16'h0100)) eesl_slave_wp_i (.clk_sys(clk_sys), .reset_n(reset_n),
		.sclClk(scl), .sclIn(scl), .sdaIn(sda), .sdaOut(sOut2), .sdaOe(sOe2), .chip_select_straps(3'h2),
		.burstSel(1'b1), .write_protect_input(wp), .supplyOk(supplyOk), .busy(busy2));
	eesl_master eesl_master_i (.scl(scl), .sdaDrv(mOe), .sda(sda));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic waitIdle();
		int n;
		n = 0;
		@(negedge clk_sys);
		while (busy !== 1'b0 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 400) begin
			bad_count++;
			$display("mismatch busy expected 0 seen %b", busy);
			summarize();
		end
	endtask
	task automatic sendChk(input logic [7:0] b, input logic expAck);
		eesl_master_i.sendByte(b, ack);
		check("ack", {7'h00, expAck}, {7'h00, ack});
	endtask
	task automatic writeSeq(input logic [7:0] a, input logic [7:0] q[$], input bit doWait);
		eesl_master_i.startCond();
		sendChk(SEL_W, 1'b1);
		sendChk(a, 1'b1);
		foreach (q[i]) sendChk(q[i], 1'b1);
		eesl_master_i.stopCond();
		check("busy", 8'h01, {7'h00, busy});
		if (doWait) waitIdle();
	endtask
	task automatic readSeq(input logic [7:0] a, input logic [7:0] exp[$]);
		eesl_master_i.startCond();
		sendChk(SEL_W, 1'b1);
		sendChk(a, 1'b1);
		eesl_master_i.startCond();
		sendChk(SEL_R, 1'b1);
		foreach (exp[i]) begin
			eesl_master_i.recvByte(i < exp.size() - 1, d);
			check("data", exp[i], d);
		end
		eesl_master_i.stopCond();
	endtask
	task automatic writeWp(input logic expBusy);
		eesl_master_i.startCond();
		sendChk({eesl_pkg::TYPE_CODE_DEFAULT, 3'h2, 1'b0}, 1'b1);
		sendChk(8'h10, 1'b1);
		sendChk(8'hAA, 1'b1);
		eesl_master_i.stopCond();
		check("busy protect", {7'h00, expBusy}, {7'h00, busy2});
		repeat (300) @(negedge clk_sys);
	endtask
	task automatic refused(input logic [7:0] sel);
		eesl_master_i.startCond();
		sendChk(sel, 1'b0);
		eesl_master_i.stopCond();
	endtask
	initial begin
		@(negedge clk_sys);
		reset_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		check("oe after reset", 8'h00, {7'h00, sOe});
		check("busy after reset", 8'h00, {7'h00, busy});
		reset_n = 1'b1;
		repeat (6) @(negedge clk_sys);
		$display("test reset done");
		foreach (rows[i]) begin
			burstSel = rows[i].burst;
			writeSeq(rows[i].addr, '{rows[i].data}, 1'b1);
			readSeq(rows[i].addr, '{rows[i].data});
		end
		$display("test table done");
		readSeq(8'hFF, '{8'hC3, 8'hA5});
		burstSel = 1'b1;
		writeSeq(8'h40, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55}, 1'b1);
		readSeq(8'h40, '{8'h55, 8'h22, 8'h33});
		eesl_master_i.startCond();
		sendChk(SEL_R, 1'b1);
		eesl_master_i.recvByte(1'b0, d);
		check("current", 8'h44, d);
		eesl_master_i.stopCond();
		burstSel = 1'b0;
		writeSeq(8'h4E, '{8'h01, 8'h02, 8'h03}, 1'b1);
		readSeq(8'h48, '{8'h03});
		readSeq(8'h40, '{8'h55});
		readSeq(8'h4E, '{8'h01, 8'h02});
		$display("test bursts done");
		refused({~eesl_pkg::TYPE_CODE_DEFAULT, STRAPS, 1'b0});
		refused({eesl_pkg::TYPE_CODE_DEFAULT, STRAPS ^ 3'h1, 1'b0});
		writeSeq(8'h20, '{8'h77}, 1'b0);
		refused(SEL_W);
		waitIdle();
		supplyOk = 1'b0;
		repeat (4) @(negedge clk_sys);
		refused(SEL_W);
		supplyOk = 1'b1;
		repeat (6) @(negedge clk_sys);
		readSeq(8'h20, '{8'h77});
		$display("test refusals done");
		wp = 1'b1;
		writeWp(1'b0);
		wp = 1'b0;
		writeWp(1'b1);
		$display("test protect done");
		summarize();
	end
endmodule
